// >>> shared/exec_defines.svh
/*
 * timing, field and reset constants for the execute block.
 * assumes inclusion by bare name from the package and the design.
 */
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH
`define PC_W 13
`define DM_AW 8
`define STACK_DEPTH 16
`define ACC_RST 8'h00
`define BCD_ADJ 4'h6
`define BCD_MAX 4'h9
`define TWO_CYCLES 2'h2
`endif

// >>> shared/exec_pkg.sv
/*
 * types of the execute block: operation codes and the decoded request.
 * assumes the defines header is on the include path.
 */
`include "exec_defines.svh"
package exec_pkg;
    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_CALL = 5'h01, OP_CLR = 5'h02, OP_CLR_BIT = 5'h03,
        OP_CLR_WDT = 5'h04, OP_INVERT_IN_PLACE = 5'h05,
        OP_INVERT_TO_ACC = 5'h06, OP_DECIMAL_ADJUST = 5'h07,
        OP_DEC = 5'h08, OP_DECREMENT_TO_ACC = 5'h09, OP_HALT = 5'h0a,
        OP_INC = 5'h0b, OP_INCREMENT_TO_ACC = 5'h0c,
        OP_JUMP_UNCONDITIONAL = 5'h0d, OP_MOV_M_TO_A = 5'h0e,
        OP_MOV_X_TO_A = 5'h0f, OP_MOV_A_TO_M = 5'h10, OP_OR_M = 5'h11,
        OP_OR_X = 5'h12, OP_OR_TO_MEMORY = 5'h13, OP_RET = 5'h14,
        OP_RET_X = 5'h15, OP_INTERRUPT_RETURN = 5'h16,
        OP_ROTATE_LEFT = 5'h17
    } op_t;
    typedef struct packed {
        op_t op;
        logic [`PC_W-1:0] addr;
        logic [`DM_AW-1:0] mem_addr;
        logic [7:0] imm;
        logic [2:0] bit_sel;
    } instr_t;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_DUMMY = 2'b01,
        ST_HALTED = 2'b10
    } state_t;
endpackage

// >>> design/exec_core.sv
/*
 * execute stage for a subset of an 8-bit core: calls, returns, jumps,
 * clear, invert, decimal adjust, inc/dec, move, or, rotate, watchdog
 * clear and halt. owns pc, stack, accumulator and the status flags.
 * assumes the fetch side presents one decoded instruction with a valid
 * level, holding it until instr_taken; data memory reads are
 * combinational (mem_rdata follows instr.mem_addr in the same cycle).
 */
// The implementer's own choices: the state encoding and the registered write strobe.
`timescale 1ns/1ps
`include "exec_defines.svh"
module exec_core
    import exec_pkg::*;
(
    input wire logic core_clk, // system clock, 50 mhz
    input wire logic rst, // async reset, active high
    input wire logic clk_en, // freezes all state while low
    input wire instr_t instr, // decoded instruction
    input wire logic instr_valid, // instruction present
    output logic instr_taken, // instruction consumed this cycle
    input wire logic [7:0] mem_rdata, // data byte at instr.mem_addr
    output logic [`DM_AW-1:0] mem_waddr, // data memory write address
    output logic [7:0] mem_wdata, // data memory write byte
    output logic mem_we, // data memory write strobe
    input wire logic wake, // wake request from interrupt logic
    output logic [`PC_W-1:0] pc, // program counter
    output logic [7:0] acc, // accumulator
    output logic zero_flag, // zero flag
    output logic carry_flag, // carry flag
    input wire logic carry_in_load, // alu outside updates carry
    input wire logic carry_in, // carry value from that alu
    input wire logic aux_carry_flag, // aux carry from prior add
    output logic timeout_flag, // watchdog timeout flag
    output logic powerdown_flag, // powerdown flag
    input wire logic watchdog_expire, // watchdog overflowed
    output logic watchdog_clear, // pulse: clear watchdog and prescaler
    output logic master_irq_enable, // global interrupt enable
    input wire logic irq_ack, // interrupt entry clears enable
    output logic halted // system clock gated off
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    state_t state_r, state_nxt;
    logic [`PC_W-1:0] pc_r, pc_nxt;
    logic [7:0] acc_r, acc_nxt;
    logic z_r, z_nxt, c_r, c_nxt, to_r, to_nxt, pd_r, pd_nxt;
    logic emi_r, emi_nxt;
    logic [`PC_W-1:0] stack_r [`STACK_DEPTH];
    logic [3:0] sp_r, sp_nxt;
    logic push;
    logic [`PC_W-1:0] push_val;
    logic [7:0] wdata_r, wdata_nxt;
    logic [`DM_AW-1:0] waddr_r, waddr_nxt;
    logic we_r, we_nxt, wdc_r, wdc_nxt;

    // bcd correction of the accumulator; returns {carry, byte}
    function automatic logic [8:0] bcd_adjust(input logic [7:0] a,
                                              input logic ac,
                                              input logic c);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, a[3:0]};
        if (a[3:0] > `BCD_MAX || ac) begin
            lo = lo + {1'b0, `BCD_ADJ};
        end
        hi = {1'b0, a[7:4]} + {4'h0, lo[4]};
        if (hi > {1'b0, `BCD_MAX} || c) begin
            hi = hi + {1'b0, `BCD_ADJ};
        end
        bcd_adjust = {hi[4] | c, hi[3:0], lo[3:0]};
    endfunction

    // zero test shared by every op that updates the zero flag
    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == 8'h00);
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    // two-cycle ops hold instr_taken low in their first cycle and raise it in the dummy cycle
    always_comb begin
        logic [8:0] adj;
        logic [7:0] res;
        adj = bcd_adjust(acc_r, aux_carry_flag, c_r);
        res = 8'h00;
        state_nxt = state_r;
        pc_nxt = pc_r;
        acc_nxt = acc_r;
        z_nxt = z_r;
        c_nxt = carry_in_load ? carry_in : c_r;
        to_nxt = to_r | watchdog_expire;
        pd_nxt = pd_r;
        emi_nxt = irq_ack ? 1'b0 : emi_r;
        sp_nxt = sp_r;
        push = 1'b0;
        push_val = pc_r + `PC_W'(1);
        waddr_nxt = instr.mem_addr;
        wdata_nxt = wdata_r;
        we_nxt = 1'b0;
        wdc_nxt = 1'b0;
        instr_taken = 1'b0;
        unique case (state_r)
            ST_HALTED: begin
                if (wake) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_DUMMY: begin
                instr_taken = 1'b1;
                state_nxt = ST_RUN;
            end
            ST_RUN: if (instr_valid) begin
                instr_taken = 1'b1;
                pc_nxt = pc_r + `PC_W'(1);
                unique case (instr.op)
                    OP_NOP: ;
                    OP_CALL: begin
                        push = 1'b1;
                        sp_nxt = sp_r + 4'h1;
                        pc_nxt = instr.addr;
                        instr_taken = 1'b0;
                        state_nxt = ST_DUMMY;
                    end
                    OP_JUMP_UNCONDITIONAL: begin
                        pc_nxt = instr.addr;
                        instr_taken = 1'b0;
                        state_nxt = ST_DUMMY;
                    end
                    OP_CLR: begin
                        wdata_nxt = 8'h00;
                        we_nxt = 1'b1;
                    end
                    OP_CLR_BIT: begin
                        wdata_nxt = mem_rdata & ~(8'h01 << instr.bit_sel);
                        we_nxt = 1'b1;
                    end
                    OP_CLR_WDT: begin
                        wdc_nxt = 1'b1;
                        to_nxt = 1'b0;
                        pd_nxt = 1'b0;
                    end
                    OP_INVERT_IN_PLACE, OP_INVERT_TO_ACC: begin
                        res = ~mem_rdata;
                        z_nxt = is_zero(res);
                        if (instr.op == OP_INVERT_TO_ACC) begin
                            acc_nxt = res;
                        end else begin
                            wdata_nxt = res;
                            we_nxt = 1'b1;
                        end
                    end
                    OP_DECIMAL_ADJUST: begin
                        wdata_nxt = adj[7:0];
                        we_nxt = 1'b1;
                        c_nxt = adj[8];
                    end
                    OP_DEC, OP_DECREMENT_TO_ACC: begin
                        res = mem_rdata - 8'h01;
                        z_nxt = is_zero(res);
                        if (instr.op == OP_DECREMENT_TO_ACC) begin
                            acc_nxt = res;
                        end else begin
                            wdata_nxt = res;
                            we_nxt = 1'b1;
                        end
                    end
                    OP_INC, OP_INCREMENT_TO_ACC: begin
                        res = mem_rdata + 8'h01;
                        z_nxt = is_zero(res);
                        if (instr.op == OP_INCREMENT_TO_ACC) begin
                            acc_nxt = res;
                        end else begin
                            wdata_nxt = res;
                            we_nxt = 1'b1;
                        end
                    end
                    OP_HALT: begin
                        wdc_nxt = 1'b1;
                        to_nxt = 1'b0;
                        pd_nxt = 1'b1;
                        state_nxt = ST_HALTED;
                    end
                    OP_MOV_M_TO_A: acc_nxt = mem_rdata;
                    OP_MOV_X_TO_A: acc_nxt = instr.imm;
                    OP_MOV_A_TO_M: begin
                        wdata_nxt = acc_r;
                        we_nxt = 1'b1;
                    end
                    OP_OR_M, OP_OR_X, OP_OR_TO_MEMORY: begin
                        res = acc_r | (instr.op == OP_OR_X ? instr.imm
                                                            : mem_rdata);
                        z_nxt = is_zero(res);
                        if (instr.op == OP_OR_TO_MEMORY) begin
                            wdata_nxt = res;
                            we_nxt = 1'b1;
                        end else begin
                            acc_nxt = res;
                        end
                    end
                    OP_RET, OP_RET_X, OP_INTERRUPT_RETURN: begin
                        sp_nxt = sp_r - 4'h1;
                        pc_nxt = stack_r[sp_r - 4'h1];
                        if (instr.op == OP_RET_X) begin
                            acc_nxt = instr.imm;
                        end
                        // pending interrupts then enter via outside logic
                        if (instr.op == OP_INTERRUPT_RETURN) begin
                            emi_nxt = 1'b1;
                        end
                    end
                    OP_ROTATE_LEFT: begin
                        wdata_nxt = {mem_rdata[6:0], mem_rdata[7]};
                        we_nxt = 1'b1;
                    end
                    default: ;
                endcase
            end
            default: state_nxt = ST_RUN;
        endcase
        // nothing is consumed while the enable holds the core frozen
        if (!clk_en) begin
            instr_taken = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // stack entries carry no reset: contents are undefined until pushed
    always_ff @(posedge core_clk) begin
        if (clk_en && push) begin
            stack_r[sp_r] <= push_val;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_RUN;
            pc_r <= '0;
            acc_r <= `ACC_RST;
            z_r <= 1'b0;
            c_r <= 1'b0;
            to_r <= 1'b0;
            pd_r <= 1'b0;
            emi_r <= 1'b0;
            sp_r <= 4'h0;
            waddr_r <= '0;
            wdata_r <= 8'h00;
            we_r <= 1'b0;
            wdc_r <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
            acc_r <= acc_nxt;
            z_r <= z_nxt;
            c_r <= c_nxt;
            to_r <= to_nxt;
            pd_r <= pd_nxt;
            emi_r <= emi_nxt;
            sp_r <= sp_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
            we_r <= we_nxt;
            wdc_r <= wdc_nxt;
        end
    end

    // outputs straight from flops, halted decoded from state_r; mem_we and watchdog_clear are also gated by clk_en
    assign pc = pc_r;
    assign acc = acc_r;
    assign zero_flag = z_r;
    assign carry_flag = c_r;
    assign timeout_flag = to_r;
    assign powerdown_flag = pd_r;
    assign master_irq_enable = emi_r;
    assign mem_waddr = waddr_r;
    assign mem_wdata = wdata_r;
    assign mem_we = we_r & clk_en;
    assign watchdog_clear = wdc_r & clk_en;
    assign halted = (state_r == ST_HALTED);
endmodule

// >>> bench/exec_core_props.sv
/*
 * port checker for the execute block.
 * assumes a bind to exec_core; sees its ports only.
 */
`timescale 1ns/1ps
`include "exec_defines.svh"
module exec_core_props
    import exec_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic rst, // reset
    input wire logic clk_en, // run enable
    input wire instr_t instr, // instruction
    input wire logic instr_valid, // present
    input wire logic instr_taken, // consumed
    input wire logic [7:0] mem_rdata, // read byte
    input wire logic [7:0] mem_wdata, // write byte
    input wire logic mem_we, // write strobe
    input wire logic [`PC_W-1:0] pc, // pc
    input wire logic [7:0] acc, // acc
    input wire logic zero_flag, // zero
    input wire logic timeout_flag, // timeout
    input wire logic powerdown_flag, // powerdown
    input wire logic watchdog_clear, // wd clear
    input wire logic master_irq_enable, // irq enable
    input wire logic halted // halted
);
    // ----
    // properties
    // ----
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_clr;
        instr_taken && instr.op == OP_CLR |=> mem_we && mem_wdata == 8'h00;
    endproperty
    a_clr: assert property (p_clr) else $error("clear bad");
    property p_inv;
        instr_taken && instr.op == OP_INVERT_IN_PLACE |=> mem_we &&
            mem_wdata == ~$past(mem_rdata) && zero_flag == (mem_wdata == 0);
    endproperty
    a_inv: assert property (p_inv) else $error("invert bad");
    property p_inc;
        instr_taken && instr.op == OP_INC |=>
            mem_we && mem_wdata == $past(mem_rdata) + 8'h01;
    endproperty
    a_inc: assert property (p_inc) else $error("increment bad");
    property p_rot;
        instr_taken && instr.op == OP_ROTATE_LEFT |=>
            mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])};
    endproperty
    a_rot: assert property (p_rot) else $error("rotate bad");
    // first cycle of a two-cycle transfer: pc loads at its edge
    property p_jump;
        instr_valid && clk_en && !halted && !instr_taken &&
            instr.op inside {OP_JUMP_UNCONDITIONAL, OP_CALL} |=>
            pc == $past(instr.addr);
    endproperty
    a_jump: assert property (p_jump) else $error("target bad");
    property p_mov;
        instr_taken && instr.op == OP_MOV_X_TO_A |=>
            acc == $past(instr.imm) && $stable(zero_flag);
    endproperty
    a_mov: assert property (p_mov) else $error("move bad");
    property p_interrupt_return;
        instr_taken && instr.op == OP_INTERRUPT_RETURN |=> master_irq_enable;
    endproperty
    a_interrupt_return: assert property (p_interrupt_return) else $error("enable bad");
    property p_halt;
        instr_taken && instr.op == OP_HALT |=> halted && powerdown_flag &&
            !timeout_flag && watchdog_clear;
    endproperty
    a_halt: assert property (p_halt) else $error("halt bad");
    property p_wdt;
        instr_taken && instr.op == OP_CLR_WDT |=>
            !timeout_flag && !powerdown_flag && watchdog_clear;
    endproperty
    a_wdt: assert property (p_wdt) else $error("wd clear bad");
endmodule

// >>> bench/data_mem_model.sv
/*
 * data memory at the far side of the execute block, 256 bytes.
 * assumes combinational reads and writes on the sampled strobe edge.
 */
`timescale 1ns/1ps
module data_mem_model (
    input wire logic core_clk, // clock
    input wire logic [7:0] raddr, // read address
    output logic [7:0] rdata, // read byte, same cycle
    input wire logic [7:0] waddr, // write address
    input wire logic [7:0] wdata, // write byte
    input wire logic we // write strobe
);
    logic [7:0] mem [256];
    // byte i holds i so every first read is predictable
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i);
        end
    end
    // combinational read, as the core expects
    assign rdata = mem[raddr];
    // write lands at the edge the strobe is seen
    always @(posedge core_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end
endmodule

// >>> bench/testbench.sv
/*
 * testbench for exec_core: operation table, decimal adjust, flow,
 * clock enable, watchdog and halt.
 * assumes the package, memory model and checker are compiled first.
 */
`timescale 1ns/1ps
`include "exec_defines.svh"
module testbench
    import exec_pkg::*;
;
    logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, instr_valid = 1'b0;
    logic wake = 1'b0, carry_in_load = 1'b0, carry_in = 1'b0;
    logic aux_carry_flag = 1'b0, watchdog_expire = 1'b0, irq_ack = 1'b0;
    instr_t instr = '0;
    logic instr_taken, mem_we, zero_flag, carry_flag, timeout_flag;
    logic powerdown_flag, watchdog_clear, master_irq_enable, halted;
    logic [7:0] mem_rdata, mem_waddr, mem_wdata, acc;
    logic [`PC_W-1:0] pc, epc = '0;
    int n_fail = 0, num_checks = 0, cyc;
    // ----
    // clock, design and far side
    // ----
    always #10 core_clk = ~core_clk;
    exec_core u_exec_core (.core_clk, .rst, .clk_en, .instr, .instr_valid,
        .instr_taken, .mem_rdata, .mem_waddr, .mem_wdata, .mem_we, .wake,
        .pc, .acc, .zero_flag, .carry_flag, .carry_in_load, .carry_in,
        .aux_carry_flag, .timeout_flag, .powerdown_flag, .watchdog_expire,
        .watchdog_clear, .master_irq_enable, .irq_ack, .halted);
    data_mem_model u_data_mem_model (.core_clk, .raddr(instr.mem_addr),
        .rdata(mem_rdata), .waddr(mem_waddr), .wdata(mem_wdata), .we(mem_we));
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(logic [15:0] g, logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one instruction; returns at the negedge after its take edge
    task automatic ex(op_t o, logic [7:0] m, logic [7:0] x,
                      logic [`PC_W-1:0] a);
        @(posedge core_clk);
        instr <= '{o, a, m, x, x[2:0]};
        instr_valid <= 1'b1;
        cyc = 0;
        @(negedge core_clk);
        while (instr_taken !== 1'b1 && cyc < 8) begin
            @(negedge core_clk);
            cyc++;
        end
        @(posedge core_clk);
        instr_valid <= 1'b0;
        epc = epc + 1'b1;
        @(negedge core_clk);
    endtask
    task automatic alu(op_t o, logic [7:0] m, logic [7:0] x, logic w,
                       logic [7:0] d, logic [7:0] a, logic z);
        ex(o, m, x, '0);
        chk(16'(cyc), 16'h0);
        chk(pc, epc);
        chk(mem_we, w);
        if (w) begin
            chk(mem_wdata, d);
        end
        chk(acc, a);
        chk(zero_flag, z);
    endtask
    task automatic daa(logic [7:0] a, logic h, logic c, logic [7:0] r,
                       logic co);
        @(posedge core_clk);
        carry_in_load <= 1'b1;
        carry_in <= c;
        aux_carry_flag <= h;
        @(posedge core_clk);
        carry_in_load <= 1'b0;
        ex(OP_MOV_X_TO_A, '0, a, '0);
        ex(OP_DECIMAL_ADJUST, 8'h20, '0, '0);
        chk(mem_wdata, r);
        chk(mem_waddr, 8'h20);
        chk(carry_flag, co);
        chk(acc, a);
        chk(zero_flag, 1'b0);
    endtask
    task automatic t_flow;
        logic [`PC_W-1:0] back;
        back = epc + 1'b1;
        ex(OP_CALL, '0, '0, 13'h0123);
        chk(16'(cyc), 16'h1);
        chk(pc, 13'h0123);
        ex(OP_JUMP_UNCONDITIONAL, '0, '0, 13'h0456);
        chk(16'(cyc), 16'h1);
        chk(pc, 13'h0456);
        ex(OP_CALL, '0, '0, 13'h1abc);
        ex(OP_RET_X, '0, 8'h3c, '0);
        chk(pc, 13'h0457);
        chk(acc, 8'h3c);
        ex(OP_RET, '0, '0, '0);
        chk(pc, back);
        chk(carry_flag, 1'b1);
        ex(OP_CALL, '0, '0, 13'h0200);
        ex(OP_INTERRUPT_RETURN, '0, '0, '0);
        chk(master_irq_enable, 1'b1);
        chk(pc, back + 1'b1);
        @(posedge core_clk);
        irq_ack <= 1'b1;
        @(posedge core_clk);
        irq_ack <= 1'b0;
        @(negedge core_clk);
        chk(master_irq_enable, 1'b0);
    endtask
    task automatic expire;
        @(posedge core_clk);
        watchdog_expire <= 1'b1;
        @(posedge core_clk);
        watchdog_expire <= 1'b0;
        @(negedge core_clk);
        chk(timeout_flag, 1'b1);
    endtask
    task automatic t_halt;
        @(posedge core_clk);
        clk_en <= 1'b0;
        instr <= '{OP_MOV_X_TO_A, 13'h0, 8'h0, 8'h55, 3'h0};
        instr_valid <= 1'b1;
        @(negedge core_clk);
        chk(instr_taken, 1'b0);
        @(posedge core_clk);
        clk_en <= 1'b1;
        instr_valid <= 1'b0;
        @(negedge core_clk);
        chk(acc, 8'h3c);
        expire();
        ex(OP_CLR_WDT, '0, '0, '0);
        chk({timeout_flag, powerdown_flag, watchdog_clear}, 3'b001);
        expire();
        ex(OP_HALT, '0, '0, '0);
        chk({halted, powerdown_flag, timeout_flag}, 3'b110);
        chk(watchdog_clear, 1'b1);
        // halted core must refuse a waiting instruction until woken
        @(posedge core_clk);
        instr.op <= OP_NOP;
        instr_valid <= 1'b1;
        repeat (2) @(negedge core_clk);
        chk(instr_taken, 1'b0);
        chk(acc, 8'h3c);
        @(posedge core_clk);
        wake <= 1'b1;
        @(posedge core_clk);
        wake <= 1'b0;
        instr_valid <= 1'b0;
        @(negedge core_clk);
        chk(halted, 1'b0);
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        chk(pc, epc);
        alu(OP_MOV_X_TO_A, 8'h00, 8'h81, 0, 8'h00, 8'h81, 0);
        alu(OP_MOV_A_TO_M, 8'h10, 8'h00, 1, 8'h81, 8'h81, 0);
        alu(OP_OR_X, 8'h00, 8'h06, 0, 8'h00, 8'h87, 0);
        alu(OP_OR_TO_MEMORY, 8'h10, 8'h00, 1, 8'h87, 8'h87, 0);
        alu(OP_ROTATE_LEFT, 8'h10, 8'h00, 1, 8'h0f, 8'h87, 0);
        alu(OP_INVERT_TO_ACC, 8'h10, 8'h00, 0, 8'h00, 8'hf0, 0);
        alu(OP_INVERT_IN_PLACE, 8'hff, 8'h00, 1, 8'h00, 8'hf0, 1);
        alu(OP_MOV_M_TO_A, 8'h10, 8'h00, 0, 8'h00, 8'h0f, 1);
        alu(OP_DEC, 8'hff, 8'h00, 1, 8'hff, 8'h0f, 0);
        alu(OP_INCREMENT_TO_ACC, 8'hff, 8'h00, 0, 8'h00, 8'h00, 1);
        alu(OP_DECREMENT_TO_ACC, 8'h01, 8'h00, 0, 8'h00, 8'h00, 1);
        alu(OP_INC, 8'hff, 8'h00, 1, 8'h00, 8'h00, 1);
        alu(OP_OR_M, 8'h10, 8'h00, 0, 8'h00, 8'h0f, 0);
        alu(OP_CLR, 8'h10, 8'h00, 1, 8'h00, 8'h0f, 0);
        alu(OP_CLR_BIT, 8'h0f, 8'h03, 1, 8'h07, 8'h0f, 0);
        alu(OP_NOP, 8'h00, 8'h00, 0, 8'h00, 8'h0f, 0);
        daa(8'h7b, 0, 0, 8'h81, 0);
        daa(8'h12, 1, 0, 8'h18, 0);
        daa(8'ha5, 0, 0, 8'h05, 1);
        daa(8'h33, 0, 1, 8'h93, 1);
        daa(8'hab, 0, 0, 8'h11, 1);
        t_flow();
        t_halt();
        conclude();
    end
    // hang guard, far beyond the hundred or so cycles the run needs
    initial begin
        #40000;
        n_fail++;
        conclude();
    end
endmodule
bind exec_core exec_core_props u_exec_core_props (.core_clk, .rst, .clk_en,
    .instr, .instr_valid, .instr_taken, .mem_rdata, .mem_wdata, .mem_we,
    .pc, .acc, .zero_flag, .timeout_flag, .powerdown_flag, .watchdog_clear,
    .master_irq_enable, .halted);
